/* File: hww_map.vh */
// register map, field positions, reset values and timing counts
// assumes a plain strobe register port with read data one cycle later
`ifndef HWW_MAP_VH
`define HWW_MAP_VH
`define HWW_ADDR_WDOG_CTRL   4'h0
`define HWW_ADDR_RST_FLAGS   4'h1
`define HWW_ADDR_PWR_CTRL    4'h2
`define HWW_ADDR_CLK_CTRL    4'h3
`define HWW_ADDR_STATUS      4'h4
`define HWW_ADDR_PA_WAKE     4'h5
`define HWW_WDOG_CTRL_RST    8'h53
`define HWW_CODE_A           5'h15
`define HWW_CODE_B           5'h0a
`define HWW_PWR_DEEP_BIT     0
`define HWW_PWR_ISO_BIT      1
`define HWW_CLK_SLOW_BIT     0
`define HWW_CLK_FAST_BIT     1
`define HWW_SRESET_NS        1000
`define HWW_CLK_NS           10
`define HWW_SRESET_CYC       ((`HWW_SRESET_NS + `HWW_CLK_NS - 1) / `HWW_CLK_NS)
`endif

/* File: hww_halt_wakeup_watchdog.v */
// halt mode entry, wake-up control and watchdog timer
// assumes the core pulses haltExec/clrWdtExec and obeys runEnable/restart
// Overview of operation
// - halt, deep select 0, both idle enables 1: idle_both_clocks, both clocks run.
// - halt, deep select 0, fast 1 slow 0: idle_fast_clock_only, fast clock only.
// - halt with deep select 1 enters deep sleep, system clock stopped.
// - any halt sets power-down flag and clears timeout flag.
// - power-up or clear-watchdog instruction clears power-down flag.
// - deep sleep clears and stops the watchdog counter.
// - deep sleep holds ports only if isolation bit set before entry.
// - sleep/idle wake on port A fall, interrupt, or watchdog overflow.
// - deep sleep wakes only on port A fall, time base 0, touch key.
// - watchdog wake sets timeout flag, resets only PC and SP.
// - port A wake resumes after halt, or restarts at 0000h from deep.
// - disabled interrupt or full stack: resume after halt, service later.
// - enabled interrupt with stack room: normal interrupt response now.
// - time base 0 wake from deep sleep restarts at 0000h.
// - interrupt flag already high at entry cannot wake the device.
// - watchdog counts the 32kHz low-speed clock, power-of-two divided.
// - period select 000..111 gives 2^8,10,12,14,15,16,17,18 cycles.
// - always-enabled option: codes 10101/01010 enable, others reset.
// - register option: 10101 disables, 01010 enables, others reset.
// - illegal enable code resets after fixed delay, sets reset flag.
// - watchdog register reset flag set by hardware, cleared by writing 0.
// - halt with all three selects 0 enters sleep, clock stopped.
// - halt, deep 0, fast 0, slow 1: idle_slow_clock_only, only sub clock runs.
// - any deep sleep wake resets the watchdog, power, clock and port A wake registers, not the flags.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "hww_map.vh"
module hww_halt_wakeup_watchdog #(
	parameter        WDOG_ALWAYS_ON = 1'b0, // configuration option
	parameter        SRESET_CYC     = `HWW_SRESET_CYC, // delay before reset
	parameter        INT_NUM        = 4 // interrupt sources
) (
	input  wire               clk,             // 100 MHz system clock
	input  wire               rst_b,           // async power-up reset
	input  wire [3:0]         regAddr,         // register address
	input  wire [7:0]         regWrData,       // write data
	input  wire               regWrEn,         // write strobe
	input  wire               regRdEn,         // read strobe
	output reg  [7:0]         regRdData,       // read data, next cycle
	input  wire               haltExec,        // halt executed, pulse
	input  wire               clrWdtExec,      // clear-watchdog, pulse
	input  wire               lowSpeedOscClock,// ~32kHz osc, async
	input  wire [7:0]         portAPins,       // port A pins, async
	input  wire [INT_NUM-1:0] intReq,          // interrupt request flags
	input  wire [INT_NUM-1:0] intEnable,       // interrupt enables
	input  wire               stackFull,       // stack has no room
	input  wire               timeBase0Int,    // time base 0 request
	input  wire               touchKeyEvent,   // touch key wake event
	output reg                runEnable,       // program may execute
	output reg                fastClkOn,       // high-speed clock gate
	output reg                subClkOn,        // sub clock gate
	output reg                ioIsolate,       // hold port states
	output reg                restartZero,     // restart at 0000h, pulse
	output reg                pcSpReset,       // reset PC and SP, pulse
	output reg                intServeNow,     // take interrupt, pulse
	output reg                deviceReset,     // full reset, pulse
	output reg                powerDownFlag,   // status power-down flag
	output reg                timeoutFlag      // status timeout flag
);
	localparam [5:0] ST_RUN = 6'h01, ST_SLEEP = 6'h02, ST_IDLE_SLOW_CLOCK_ONLY = 6'h04,
		ST_IDLE_BOTH_CLOCKS = 6'h08, ST_IDLE_FAST_CLOCK_ONLY = 6'h10, ST_DEEP = 6'h20;

	reg        rstSync1, rstSync2;
	wire       rstN = rstSync2;
	reg [5:0]  stateReg;
	reg [7:0]  wdogCtrlReg;
	reg        wdogRegResetFlagReg;
	reg [1:0]  pwrCtrlReg;
	reg [1:0]  clkCtrlReg;
	reg [7:0]  portAWakeEnableReg;
	reg [INT_NUM-1:0] intMaskReg;
	reg [2:0]  lsSync, paSyncA;
	reg [7:0]  paSync1, paSync2, paSync3, paStable;
	reg [18:0] wdogCntReg;
	reg        lsStable;
	reg [15:0] sresetCntReg;
	reg        sresetPend;

	function codeLegal;
		input [4:0] c;
		codeLegal = (c == `HWW_CODE_A) || (c == `HWW_CODE_B);
	endfunction

	// terminal count index per period select
	function [4:0] periodBit;
		input [2:0] s;
		case (s)
		3'h0: periodBit = 5'd8;
		3'h1: periodBit = 5'd10;
		3'h2: periodBit = 5'd12;
		3'h3: periodBit = 5'd14;
		3'h4: periodBit = 5'd15;
		3'h5: periodBit = 5'd16;
		3'h6: periodBit = 5'd17;
		default: periodBit = 5'd18;
		endcase
	endfunction

	wire [4:0] wdogCode = wdogCtrlReg[7:3];
	wire wdogOn = (WDOG_ALWAYS_ON != 1'b0) ? codeLegal(wdogCode)
		: (wdogCode == `HWW_CODE_B);
	wire inDeep  = (stateReg == ST_DEEP);
	wire inLight = ~inDeep && (stateReg != ST_RUN);

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstSync1 <= 1'b0;
			rstSync2 <= 1'b0;
		end else begin
			rstSync1 <= 1'b1;
			rstSync2 <= rstSync1;
		end
	end

	// pins: three stages, change counts when stages two and three agree
	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			lsSync   <= 3'h0;
			lsStable <= 1'b0;
			paSync1  <= 8'hff;
			paSync2  <= 8'hff;
			paSync3  <= 8'hff;
			paStable <= 8'hff;
		end else begin
			lsSync  <= {lsSync[1:0], lowSpeedOscClock};
			paSync1 <= portAPins;
			paSync2 <= paSync1;
			paSync3 <= paSync2;
			if (lsSync[1] == lsSync[2])
				lsStable <= lsSync[2];
			paStable <= (paStable & ~(paSync2 ^ paSync3))
				| (paSync3 & ~(paSync2 ^ paSync3));
		end
	end

	wire [7:0] paNext = (paStable & ~(paSync2 ^ paSync3))
		| (paSync3 & ~(paSync2 ^ paSync3));
	wire lsNext = (lsSync[1] == lsSync[2]) ? lsSync[2] : lsStable;
	wire lsTick = lsNext & ~lsStable;
	wire paFall = |(paStable & ~paNext & portAWakeEnableReg);
	wire wdogOvf = wdogCntReg[periodBit(wdogCtrlReg[2:0])];
	wire [INT_NUM-1:0] intWake = intReq & intMaskReg;
	wire intServe = |(intWake & intEnable) && !stackFull;
	wire lightWake = paFall || (|intWake) || wdogOvf;
	wire deepWake = paFall || timeBase0Int || touchKeyEvent;
	wire haltGo = haltExec && (stateReg == ST_RUN);
	wire wrWdog = regWrEn && (regAddr == `HWW_ADDR_WDOG_CTRL);

	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			stateReg            <= ST_RUN;
			wdogCtrlReg         <= `HWW_WDOG_CTRL_RST;
			wdogRegResetFlagReg <= 1'b0;
			pwrCtrlReg          <= 2'h0;
			clkCtrlReg          <= 2'h0;
			portAWakeEnableReg  <= 8'h00;
			intMaskReg          <= {INT_NUM{1'b1}};
			wdogCntReg          <= 19'h0;
			sresetCntReg        <= 16'h0;
			sresetPend          <= 1'b0;
			regRdData           <= 8'h00;
			runEnable           <= 1'b1;
			fastClkOn           <= 1'b1;
			subClkOn            <= 1'b1;
			ioIsolate           <= 1'b0;
			restartZero         <= 1'b0;
			pcSpReset           <= 1'b0;
			intServeNow         <= 1'b0;
			deviceReset         <= 1'b0;
			powerDownFlag       <= 1'b0;
			timeoutFlag         <= 1'b0;
		end else begin
			restartZero <= 1'b0;
			pcSpReset   <= 1'b0;
			intServeNow <= 1'b0;
			deviceReset <= 1'b0;
			regRdData   <= 8'h00;
			if (regRdEn) begin
				case (regAddr)
				`HWW_ADDR_WDOG_CTRL: regRdData <= wdogCtrlReg;
				`HWW_ADDR_RST_FLAGS: regRdData <= {7'h0, wdogRegResetFlagReg};
				`HWW_ADDR_PWR_CTRL:  regRdData <= {6'h0, pwrCtrlReg};
				`HWW_ADDR_CLK_CTRL:  regRdData <= {6'h0, clkCtrlReg};
				`HWW_ADDR_STATUS:    regRdData <= {2'h0, stateReg};
				`HWW_ADDR_PA_WAKE:   regRdData <= portAWakeEnableReg;
				default:             regRdData <= 8'h00;
				endcase
			end
			if (regWrEn) begin
				case (regAddr)
				`HWW_ADDR_WDOG_CTRL: wdogCtrlReg <= regWrData;
				`HWW_ADDR_PWR_CTRL:  pwrCtrlReg <= regWrData[1:0];
				`HWW_ADDR_CLK_CTRL:  clkCtrlReg <= regWrData[1:0];
				`HWW_ADDR_PA_WAKE:   portAWakeEnableReg <= regWrData;
				default: ;
				endcase
			end
			// flag cleared only by writing 0; set wins over clear
			if (regWrEn && regAddr == `HWW_ADDR_RST_FLAGS
				&& !regWrData[0])
				wdogRegResetFlagReg <= 1'b0;
			// illegal code: count the fixed delay then reset
			if (!codeLegal(wdogCode) && !wrWdog) begin
				if (!sresetPend) begin
					sresetPend   <= 1'b1;
					sresetCntReg <= 16'h0;
				end else if (sresetCntReg == SRESET_CYC[15:0] - 16'h1) begin
					sresetPend          <= 1'b0;
					deviceReset         <= 1'b1;
					wdogRegResetFlagReg <= 1'b1;
					wdogCtrlReg         <= `HWW_WDOG_CTRL_RST;
				end else
					sresetCntReg <= sresetCntReg + 16'h1;
			end else if (codeLegal(wdogCode))
				sresetPend <= 1'b0;
			// watchdog counter
			if (haltGo || clrWdtExec || inDeep || !wdogOn)
				wdogCntReg <= 19'h0;
			else if (wdogOvf)
				wdogCntReg <= 19'h0;
			else if (lsTick)
				wdogCntReg <= wdogCntReg + 19'h1;
			if (clrWdtExec)
				powerDownFlag <= 1'b0;
			// overflow while running is a full device reset
			if (wdogOvf && wdogOn && !inDeep) begin
				timeoutFlag <= 1'b1;
				if (stateReg == ST_RUN)
					deviceReset <= 1'b1;
			end
			case (stateReg)
			ST_RUN: begin
				if (haltExec) begin
					powerDownFlag <= 1'b1;
					timeoutFlag   <= 1'b0;
					intMaskReg    <= ~intReq;
					runEnable     <= 1'b0;
					if (pwrCtrlReg[`HWW_PWR_DEEP_BIT]) begin
						stateReg  <= ST_DEEP;
						fastClkOn <= 1'b0;
						subClkOn  <= 1'b0;
						// ports held only when isolation was requested
						ioIsolate <= pwrCtrlReg[`HWW_PWR_ISO_BIT];
					end else begin
						case (clkCtrlReg)
						2'h3: stateReg <= ST_IDLE_BOTH_CLOCKS;
						2'h2: stateReg <= ST_IDLE_FAST_CLOCK_ONLY;
						2'h1: stateReg <= ST_IDLE_SLOW_CLOCK_ONLY;
						default: stateReg <= ST_SLEEP;
						endcase
						fastClkOn <= clkCtrlReg[`HWW_CLK_FAST_BIT];
						subClkOn  <= clkCtrlReg[`HWW_CLK_SLOW_BIT];
					end
				end
			end
			ST_SLEEP, ST_IDLE_SLOW_CLOCK_ONLY, ST_IDLE_BOTH_CLOCKS, ST_IDLE_FAST_CLOCK_ONLY: begin
				if (lightWake) begin
					stateReg  <= ST_RUN;
					runEnable <= 1'b1;
					fastClkOn <= 1'b1;
					subClkOn  <= 1'b1;
					if (wdogOvf)
						pcSpReset <= 1'b1;
					else if (!paFall)
						intServeNow <= intServe;
					// port A wake just resumes after the halt
				end
			end
			ST_DEEP: begin
				if (deepWake) begin
					// every wake from deep sleep is a register reset
					stateReg    <= ST_RUN;
					runEnable   <= 1'b1;
					fastClkOn   <= 1'b1;
					subClkOn    <= 1'b1;
					restartZero <= 1'b1;
					deviceReset <= 1'b1;
					wdogCtrlReg <= `HWW_WDOG_CTRL_RST;
					pwrCtrlReg  <= 2'h0;
					clkCtrlReg  <= 2'h0;
					portAWakeEnableReg <= 8'h00;
				end
			end
			default: stateReg <= ST_RUN;
			endcase
		end
	end
endmodule // hww_halt_wakeup_watchdog

/* File: hww_chk.sv */
// concurrent checks on the halt, wake-up and watchdog block ports
// assumes it is bound to hww_halt_wakeup_watchdog and sees only its ports
`timescale 1ns/1ps
module hww_chk #(
	parameter INT_NUM = 4 // interrupt sources
) (
	input wire               clk,           // system clock
	input wire               rst_b,         // async reset, low active
	input wire               haltExec,      // halt pulse
	input wire               clrWdtExec,    // clear-watchdog pulse
	input wire [INT_NUM-1:0] intReq,        // interrupt requests
	input wire [INT_NUM-1:0] intEnable,     // interrupt enables
	input wire               stackFull,     // stack full
	input wire               runEnable,     // program runs
	input wire               restartZero,   // restart pulse
	input wire               pcSpReset,     // pc and sp reset pulse
	input wire               intServeNow,   // interrupt response pulse
	input wire               deviceReset,   // full reset pulse
	input wire               powerDownFlag, // power-down flag
	input wire               timeoutFlag    // timeout flag
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_halt_sets_pdf: assert property (
		haltExec && runEnable |=> powerDownFlag && !timeoutFlag)
		else $error("halt left flags wrong");
	a_halt_stops_run: assert property (
		haltExec && runEnable |=> !runEnable)
		else $error("halt did not stop the program");
	a_pdf_rise_cause: assert property (
		$rose(powerDownFlag) |-> $past(haltExec))
		else $error("power-down flag rose without halt");
	a_cw_clears_pdf: assert property (
		clrWdtExec && runEnable && !haltExec |=> !powerDownFlag)
		else $error("clear-watchdog kept power-down flag");
	a_pdf_fall_cause: assert property (
		$fell(powerDownFlag) |->
		$past(clrWdtExec) || deviceReset || $past(deviceReset))
		else $error("power-down flag fell without cause");
	a_tmo_rise_cause: assert property (
		$rose(timeoutFlag) |-> pcSpReset || deviceReset)
		else $error("timeout flag rose without overflow");
	a_deep_restart_rst: assert property (
		restartZero |-> deviceReset && runEnable)
		else $error("restart without full reset");
	a_serve_needs_room: assert property (
		intServeNow |-> !$past(stackFull) && $past(|(intReq & intEnable)))
		else $error("interrupt served without room or enable");
	a_serve_while_run: assert property (
		intServeNow |-> runEnable)
		else $error("interrupt served while halted");
	c_halt: cover property (haltExec && runEnable);
	c_serve: cover property (intServeNow);
	c_deep: cover property (restartZero);
	c_wdog: cover property (pcSpReset);
endmodule // hww_chk

bind hww_halt_wakeup_watchdog hww_chk #(.INT_NUM(INT_NUM)) i_hww_chk (
	.clk(clk), .rst_b(rst_b), .haltExec(haltExec),
	.clrWdtExec(clrWdtExec), .intReq(intReq), .intEnable(intEnable),
	.stackFull(stackFull), .runEnable(runEnable),
	.restartZero(restartZero), .pcSpReset(pcSpReset),
	.intServeNow(intServeNow), .deviceReset(deviceReset),
	.powerDownFlag(powerDownFlag), .timeoutFlag(timeoutFlag));

/* File: tb_halt_wakeup_watchdog.sv */
// self-checking bench for the halt, wake-up and watchdog block
// assumes hww_map.vh on the include path and the checker bound beside it
`timescale 1ns/1ps
`include "hww_map.vh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; \
	$display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb_halt_wakeup_watchdog;
	localparam SC = 4; // short reset delay keeps the run brief
	reg        clk = 0, rst_b = 0, we = 0, re = 0, halt = 0, clrw = 0;
	reg        osc = 0, sfull = 0, tb0 = 0, tk = 0;
	reg  [3:0] addr = 0, ireq = 0, ien = 0;
	reg  [7:0] wd = 0, pa = 8'hff, d;
	wire [7:0] rdData;
	wire       runEn, fastOn, subOn, iso, rz, pcsp, serve, devRst, power_down_flag, tof;
	int        failures = 0, checks = 0, n, i;
	initial forever #5 clk = ~clk;
	initial forever #20 osc = ~osc; // 4 system cycles per slow tick
	hww_halt_wakeup_watchdog #(.SRESET_CYC(SC)) i_hww_halt_wakeup_watchdog (
		.clk(clk), .rst_b(rst_b), .regAddr(addr), .regWrData(wd),
		.regWrEn(we), .regRdEn(re), .regRdData(rdData), .haltExec(halt),
		.clrWdtExec(clrw), .lowSpeedOscClock(osc), .portAPins(pa),
		.intReq(ireq), .intEnable(ien), .stackFull(sfull),
		.timeBase0Int(tb0), .touchKeyEvent(tk), .runEnable(runEn),
		.fastClkOn(fastOn), .subClkOn(subOn), .ioIsolate(iso),
		.restartZero(rz), .pcSpReset(pcsp), .intServeNow(serve),
		.deviceReset(devRst), .powerDownFlag(power_down_flag), .timeoutFlag(tof));
	task tally_and_finish;
		if (failures == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task wr(input [3:0] a, input [7:0] v);
		@(posedge clk); we <= 1; addr <= a; wd <= v;
		@(posedge clk); we <= 0;
	endtask
	task rd(input [3:0] a);
		@(posedge clk); re <= 1; addr <= a;
		@(posedge clk); re <= 0;
		#1 d = rdData;
	endtask
	task do_halt;
		@(posedge clk); halt <= 1;
		@(posedge clk); halt <= 0;
		#1;
	endtask
	// bounded wait for the program to run again; n counts cycles waited
	task wait_run(input int lim);
		for (n = 1; n <= lim; n++) begin
			@(posedge clk); #1;
			if (runEn === 1'b1) break;
		end
		if (n > lim) begin
			failures++;
			$display("[FAIL] wakeCycles exp %0d got %0d", lim, n);
		end
	endtask
	task t_reset;
		rd(`HWW_ADDR_WDOG_CTRL); `CHK("wdogCtrl", `HWW_WDOG_CTRL_RST, d)
		rd(4'hf); `CHK("unmapped", 8'h00, d)
	endtask
	task t_modes; // sleep, idle_slow_clock_only, idle_fast_clock_only, idle_both_clocks in turn
		for (i = 0; i < 4; i++) begin
			wr(`HWW_ADDR_CLK_CTRL, i[7:0]);
			ien <= 4'h1; sfull <= (i == 3);
			do_halt();
			`CHK("fastOn", i[1], fastOn)
			`CHK("subOn", i[0], subOn)
			`CHK("pdf", 1'b1, power_down_flag)
			`CHK("tof", 1'b0, tof)
			@(posedge clk); ireq <= 4'h1;
			wait_run(10);
			`CHK("serve", (i != 3), serve)
			ireq <= 0; sfull <= 0; clrw <= 1;
			@(posedge clk); clrw <= 0;
			@(posedge clk); #1 `CHK("pdfClr", 1'b0, power_down_flag)
		end
	endtask
	task t_pending; // a request already high cannot wake
		wr(`HWW_ADDR_CLK_CTRL, 8'h00); wr(`HWW_ADDR_PA_WAKE, 8'h01);
		ireq <= 4'h2;
		do_halt();
		repeat (20) @(posedge clk);
		#1 `CHK("staySleep", 1'b0, runEn)
		pa <= 8'hfe;
		wait_run(12);
		`CHK("paResume", 1'b0, rz)
		ireq <= 0; pa <= 8'hff;
	endtask
	task t_deep;
		wr(`HWW_ADDR_PWR_CTRL, 8'h03);
		do_halt();
		`CHK("deepFast", 1'b0, fastOn)
		`CHK("deepSub", 1'b0, subOn)
		`CHK("iso", 1'b1, iso)
		ireq <= 4'h1;
		repeat (20) @(posedge clk);
		#1 `CHK("deepIgnore", 1'b0, runEn)
		ireq <= 0; tb0 <= 1;
		wait_run(10);
		`CHK("restart", 1'b1, rz)
		`CHK("devRst", 1'b1, devRst)
		tb0 <= 0;
		rd(`HWW_ADDR_PWR_CTRL); `CHK("pwrCleared", 8'h00, d)
	endtask
	task t_badcode;
		wr(`HWW_ADDR_WDOG_CTRL, 8'h03);
		for (n = 1; n < 20 && devRst !== 1'b1; n++) begin
			@(posedge clk); #1;
		end
		`CHK("delayOk", 1'b1, (n >= SC && n <= SC + 2))
		rd(`HWW_ADDR_RST_FLAGS); `CHK("wrfSet", 1'b1, d[0])
		wr(`HWW_ADDR_RST_FLAGS, 8'h01);
		rd(`HWW_ADDR_RST_FLAGS); `CHK("wrfHold", 1'b1, d[0])
		wr(`HWW_ADDR_RST_FLAGS, 8'h00);
		rd(`HWW_ADDR_RST_FLAGS); `CHK("wrfClr", 1'b0, d[0])
		rd(`HWW_ADDR_WDOG_CTRL); `CHK("wdogBack", `HWW_WDOG_CTRL_RST, d)
	endtask
	task t_wdog; // 2^8 slow ticks of 4 cycles each
		wr(`HWW_ADDR_WDOG_CTRL, {`HWW_CODE_B, 3'b000});
		do_halt();
		wait_run(1200);
		`CHK("span", 1'b1, (n > 1000 && n < 1050))
		`CHK("tofSet", 1'b1, tof)
		`CHK("pcsp", 1'b1, pcsp)
		`CHK("pdfKept", 1'b1, power_down_flag)
		// disabling code: no overflow wake and no reset while asleep
		wr(`HWW_ADDR_WDOG_CTRL, {`HWW_CODE_A, 3'b000});
		do_halt();
		repeat (1100) @(posedge clk);
		#1 `CHK("wdogOff", 1'b0, runEn)
		`CHK("offNoTof", 1'b0, tof)
		ireq <= 4'h1;
		wait_run(4);
		ireq <= 0;
		wr(`HWW_ADDR_WDOG_CTRL, 8'h53);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1;
		repeat (3) @(posedge clk);
		t_reset(); t_modes(); t_pending(); t_deep(); t_badcode(); t_wdog();
		tally_and_finish();
	end
	initial begin
		#100000;
		failures++;
		tally_and_finish();
	end
endmodule // tb_halt_wakeup_watchdog
